// *** core/sgigen_pkg.sv ***
// sgigen_pkg: field layout, encodings and carrier types of the sgi generate registers.
// assumes a 64-bit coprocessor write port from the processor pipeline.
package sgigen_pkg;

  // coprocessor encodings of the two write-only registers
  localparam logic [3:0] SGIGEN_COPROC    = 4'hF;
  localparam logic [3:0] SGIGEN_CRM       = 4'hC;
  localparam logic [3:0] SGIGEN_OPC_GRP0  = 4'h2;
  localparam logic [3:0] SGIGEN_OPC_GRP1  = 4'h0;

  // field positions of the 64-bit written value
  localparam int SGIGEN_AFFINITY_LEVEL_THREE_LSB  = 48;
  localparam int SGIGEN_RS_LSB    = 44;
  localparam int SGIGEN_IRM_BIT   = 40;
  localparam int SGIGEN_AFFINITY_LEVEL_TWO_LSB  = 32;
  localparam int SGIGEN_INTERRUPT_NUMBER_LSB = 24;
  localparam int SGIGEN_AFFINITY_LEVEL_ONE_LSB  = 16;
  localparam int SGIGEN_MASK_LSB  = 0;

  // trap syndrome code for a trapped coprocessor access
  localparam logic [5:0] SGIGEN_TRAP_CODE = 6'h03;
  // value of both routing fields that sends interrupts to the monitor
  localparam logic [1:0] SGIGEN_ROUTE_MON = 2'h3;

  // exception levels
  typedef enum logic [1:0] {
    SGIGEN_EL0 = 2'b00,
    SGIGEN_EL1 = 2'b01,
    SGIGEN_EL2 = 2'b10,
    SGIGEN_EL3 = 2'b11
  } sgigen_el_type;

  // outcome of one access
  typedef enum logic [1:0] {
    SGIGEN_OK     = 2'b00,
    SGIGEN_UNDEF  = 2'b01,
    SGIGEN_TO_EL2 = 2'b10,
    SGIGEN_TO_EL3 = 2'b11
  } sgigen_outcome_type;

  // coprocessor write request
  typedef struct packed {
    logic [3:0]    coproc;
    logic [3:0]    crm;
    logic [3:0]    opc1;
    logic [31:0]   low_word;
    logic [31:0]   high_word;
    sgigen_el_type level;
    logic          monitor_mode;
  } sgigen_write_type;

  // processor control state that steers the access checks
  typedef struct packed {
    logic el2_enabled;
    logic el3_present;
    logic nonsecure_bit;
    logic [1:0] irq_fiq_route;
    logic system_register_enable;
    logic hyp_system_register_enable;
    logic monitor_system_register_enable;
    logic trap_coprocessor_c12;
    logic trap_common_regs;
    logic fiq_route_to_hyp;
    logic irq_route_to_hyp;
    logic range_select_support;
    logic dist_range_support;
    logic rs_nonzero_ignores;
  } sgigen_ctrl_type;

  // generate request towards the distributor
  typedef struct packed {
    logic [7:0]  affinity_level_three;
    logic [7:0]  affinity_level_two;
    logic [7:0]  affinity_level_one;
    logic [3:0]  range_selector;
    logic [3:0]  interrupt_number;
    logic [15:0] target_core_mask;
    logic        routing_mode_bit;
    logic        group1;
    logic        secure;
  } sgigen_req_type;

endpackage : sgigen_pkg

// *** core/sgigen_access_check.sv ***
// sgigen_access_check: decides undefined, trap or accept for one register write.
// assumes control inputs are stable in the cycle of the write; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module sgigen_access_check
  import sgigen_pkg::*;
(
  input  wire sgigen_pkg::sgigen_el_type   level_in,
  input  wire logic                        monitor_mode_in,
  input  wire sgigen_pkg::sgigen_ctrl_type ctrl_in,
  output sgigen_pkg::sgigen_outcome_type   outcome_out
);
  logic hyp_trap;
  logic mon_route;

  // with el2 enabled, any of the four hypervisor controls traps an el1 write that passes the enable check
  assign hyp_trap  = ctrl_in.el2_enabled & (ctrl_in.trap_coprocessor_c12 |
                     ctrl_in.trap_common_regs | ctrl_in.fiq_route_to_hyp |
                     ctrl_in.irq_route_to_hyp);
  assign mon_route = ctrl_in.el3_present & (ctrl_in.irq_fiq_route == SGIGEN_ROUTE_MON);

  // priority order follows the access pseudocode: c12 trap precedes the enable check
  always_comb
  begin
    outcome_out = SGIGEN_OK;
    case (level_in)
      SGIGEN_EL0: outcome_out = SGIGEN_UNDEF;                      // [R13]
      SGIGEN_EL1:
      begin
        if (ctrl_in.el2_enabled & ctrl_in.trap_coprocessor_c12)
          outcome_out = SGIGEN_TO_EL2;                               // [R14]
        else if (!ctrl_in.system_register_enable)
          outcome_out = SGIGEN_UNDEF;                                // [R13]
        else if (hyp_trap)
          outcome_out = SGIGEN_TO_EL2;                               // [R14]
        else if (mon_route & !monitor_mode_in)
          outcome_out = SGIGEN_TO_EL3;                               // [R15]
      end
      SGIGEN_EL2:
      begin
        if (!ctrl_in.hyp_system_register_enable)
          outcome_out = SGIGEN_UNDEF;                                // [R13]
        else if (mon_route)
          outcome_out = SGIGEN_TO_EL3;                               // [R15]
      end
      SGIGEN_EL3:
      begin
        if (!ctrl_in.monitor_system_register_enable)
          outcome_out = SGIGEN_UNDEF;                                // [R13]
      end
      default: outcome_out = SGIGEN_UNDEF;
    endcase
  end
endmodule : sgigen_access_check
`default_nettype wire

// *** core/sgigen_field_decode.sv ***
// sgigen_field_decode: splits a 64-bit written value into request fields.
// assumes the caller judges range selector support; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module sgigen_field_decode
  import sgigen_pkg::*;
(
  input  wire logic [63:0]   value_in,
  output sgigen_pkg::sgigen_req_type fields_out
);
  // reserved bits 63:56, 43:41, 31:28 are simply not carried
  always_comb
  begin
    fields_out                      = '0;
    fields_out.routing_mode_bit     = value_in[SGIGEN_IRM_BIT];            // [R1]
    fields_out.interrupt_number     = value_in[SGIGEN_INTERRUPT_NUMBER_LSB +: 4];     // [R3]
    fields_out.range_selector       = value_in[SGIGEN_RS_LSB +: 4];        // [R4]
    fields_out.target_core_mask     = value_in[SGIGEN_MASK_LSB +: 16];     // [R4]
    // affinity path and mask are reserved under broadcast routing
    if (!value_in[SGIGEN_IRM_BIT])
    begin
      fields_out.affinity_level_three = value_in[SGIGEN_AFFINITY_LEVEL_THREE_LSB +: 8];    // [R2]
      fields_out.affinity_level_two   = value_in[SGIGEN_AFFINITY_LEVEL_TWO_LSB +: 8];    // [R2]
      fields_out.affinity_level_one   = value_in[SGIGEN_AFFINITY_LEVEL_ONE_LSB +: 8];    // [R2]
    end
    else
    begin
      fields_out.target_core_mask     = 16'h0000;
    end
  end
endmodule : sgigen_field_decode
`default_nettype wire

// *** core/sgigen_regs.sv ***
// sgigen_regs: group 0 / group 1 software generated interrupt registers.
// assumes a one-cycle coprocessor write strobe and a distributor that always accepts.
// Operation
// R1: routing mode 0 targets the affinity path plus mask, 1 targets every core but the writer.
// R2: affinity fields at 55:48, 39:32, 23:16 form the cluster path and read as zero under mode 1.
// R3: bits 27:24 carry the interrupt number; bits 63:56, 43:41, 31:28 are reserved.
// R4: mask bit n addresses core range_selector*16+n, selector in bits 47:44.
// R5: selector is zero without support; unsupported nonzero selector is ignored or zeroed.
// R6: the distributor ignores mask bits for cores that do not exist.
// R7: the distributor always accepts generate requests, and may discard them.
// R8: group 0 serves secure writes; nonsecure group 0 is gated per target by access control.
// R9: with security enabled, nonsecure writes never reach a forbidden target.
// R10: writes from monitor mode count as secure whatever the nonsecure bit says.
// R11: group 1 requests carry the security state current at the write.
// R12: coprocessor 15, crm 12 select the pair; opcode 2 is group 0, opcode 0 group 1.
// R13: el0 writes are undefined, as are el1/el2/el3 writes with their enable at zero.
// R14: el1 writes with el2 enabled trap to el2 with code 3 on any hypervisor control.
// R15: with el3 present and both routings at 11, el2 and non-monitor el1 writes trap to el3.
// R16: an accepted write joins second word over first and issues exactly one request.
`timescale 1ns/10ps
`default_nettype none
module sgigen_regs
  import sgigen_pkg::*;
(
  input  wire logic                         clock_in,
  input  wire logic                         resetn_in,
  input  wire logic                         write_valid_in,
  input  wire sgigen_pkg::sgigen_write_type write_in,
  input  wire sgigen_pkg::sgigen_ctrl_type  ctrl_in,
  output logic                              req_valid_out,
  output sgigen_pkg::sgigen_req_type        req_out,
  output logic                              undef_out,
  output logic                              trap_el2_out,
  output logic                              trap_el3_out,
  output logic [5:0]                        trap_code_out
);
  import sgigen_pkg::*;

  logic               hit;
  logic               is_grp0;
  logic [63:0]        value;
  sgigen_req_type     fields;
  sgigen_outcome_type outcome;
  logic               rs_drop;
  logic               accept;
  logic               secure_now;
  logic               req_valid_q;
  sgigen_req_type     req_q;
  logic               undef_q;
  logic               trap_el2_q;
  logic               trap_el3_q;

  // register select from the coprocessor encoding
  assign hit     = write_valid_in & (write_in.coproc == SGIGEN_COPROC) &
                   (write_in.crm == SGIGEN_CRM) &
                   ((write_in.opc1 == SGIGEN_OPC_GRP0) |
                    (write_in.opc1 == SGIGEN_OPC_GRP1));                 // [R12]
  assign is_grp0 = (write_in.opc1 == SGIGEN_OPC_GRP0);                  // [R12]
  assign value   = {write_in.high_word, write_in.low_word};             // [R16]

  sgigen_field_decode u_decode (
    .value_in   (value),
    .fields_out (fields)
  );

  sgigen_access_check u_check (
    .level_in        (write_in.level),
    .monitor_mode_in (write_in.monitor_mode),
    .ctrl_in         (ctrl_in),
    .outcome_out     (outcome)
  );

  // nonzero selector the processor supports but the distributor does not: the write is dropped when strapped so
  assign rs_drop = ctrl_in.range_select_support & !ctrl_in.dist_range_support &
                   (fields.range_selector != 4'h0) & ctrl_in.rs_nonzero_ignores; // [R5]
  assign accept  = hit & (outcome == SGIGEN_OK) & !rs_drop;

  // el3 and monitor mode are secure regardless of the nonsecure bit
  assign secure_now = (write_in.level == SGIGEN_EL3) | write_in.monitor_mode |
                      !ctrl_in.nonsecure_bit;                            // [R10]

  // one request per accepted write, held one cycle
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      req_valid_q <= 1'b0;
    else
      req_valid_q <= accept;                                             // [R16]
  end

  // request payload; selector forced to zero where it is not supported
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      req_q <= '0;
    else if (accept)
    begin
      req_q        <= fields;                                            // [R1] [R2] [R3]
      req_q.group1 <= !is_grp0;                                          // [R8]
      req_q.secure <= secure_now;                                        // [R11]
      if (!ctrl_in.range_select_support | !ctrl_in.dist_range_support)
        req_q.range_selector <= 4'h0;                                    // [R5]
    end
  end

  // exception indications, one cycle each
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      undef_q    <= 1'b0;
      trap_el2_q <= 1'b0;
      trap_el3_q <= 1'b0;
    end
    else
    begin
      undef_q    <= hit & (outcome == SGIGEN_UNDEF);                     // [R13]
      trap_el2_q <= hit & (outcome == SGIGEN_TO_EL2);                    // [R14]
      trap_el3_q <= hit & (outcome == SGIGEN_TO_EL3);                    // [R15]
    end
  end

  assign req_valid_out = req_valid_q;
  assign req_out       = req_q;
  assign undef_out     = undef_q;
  assign trap_el2_out  = trap_el2_q;
  assign trap_el3_out  = trap_el3_q;
  assign trap_code_out = trap_el2_q ? SGIGEN_TRAP_CODE : 6'h00;          // [R14]

  // the distributor end (mask filtering, access control) keeps R6, R7, R9

  a_el0_undef : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && write_in.level == SGIGEN_EL0) |=> undef_out && !req_valid_out)
    else $error("el0 write not undefined"); // [R13]
  a_el1_enable : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && write_in.level == SGIGEN_EL1 && !ctrl_in.system_register_enable
     && !(ctrl_in.el2_enabled && ctrl_in.trap_coprocessor_c12)) |=> undef_out)
    else $error("el1 disabled write not undefined"); // [R13]
  a_hyp_trap : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && write_in.level == SGIGEN_EL1 && ctrl_in.el2_enabled
     && ctrl_in.irq_route_to_hyp && ctrl_in.system_register_enable)
    |=> trap_el2_out && trap_code_out == 6'h03)
    else $error("el1 write not trapped to el2"); // [R14]
  a_mon_trap : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (hit && write_in.level == SGIGEN_EL2 && ctrl_in.hyp_system_register_enable
     && ctrl_in.el3_present && ctrl_in.irq_fiq_route == 2'b11) |=> trap_el3_out)
    else $error("el2 write not trapped to el3"); // [R15]
  a_one_request : assert property (@(posedge clock_in) disable iff (!resetn_in)
    req_valid_out && !$past(accept) |-> 1'b0)
    else $error("request without accepted write"); // [R16]
  a_interrupt_number_carry : assert property (@(posedge clock_in) disable iff (!resetn_in)
    accept |=> req_out.interrupt_number == $past(value[27:24]))
    else $error("interrupt number not carried"); // [R3]
  a_bcast_aff : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (accept && value[40]) |=> req_out.routing_mode_bit && req_out.affinity_level_two == 8'h00)
    else $error("broadcast affinity not zero"); // [R2]
  a_group_sel : assert property (@(posedge clock_in) disable iff (!resetn_in)
    accept |=> req_out.group1 == $past(write_in.opc1 == SGIGEN_OPC_GRP1))
    else $error("group not from opcode"); // [R12]
  a_monitor_sec : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (accept && write_in.monitor_mode) |=> req_out.secure)
    else $error("monitor write not secure"); // [R10]
  a_rs_zero : assert property (@(posedge clock_in) disable iff (!resetn_in)
    (accept && !ctrl_in.range_select_support) |=> req_out.range_selector == 4'h0)
    else $error("selector not zeroed"); // [R5]

  c_grp0 : cover property (@(posedge clock_in) accept && is_grp0);
  c_bcast : cover property (@(posedge clock_in) accept && value[40]);
  c_trap3 : cover property (@(posedge clock_in) trap_el3_out);
  c_undef : cover property (@(posedge clock_in) undef_out);
endmodule : sgigen_regs
`default_nettype wire

// *** tb/sgigen_dist_model.sv ***
// sgigen_dist_model: behavioural distributor that takes generate requests.
// assumes one-cycle request pulses on the processor clock.
`timescale 1ns/10ps
`default_nettype none
module sgigen_dist_model
  import sgigen_pkg::*;
(
  input  wire logic                       clock_in,
  input  wire logic                       resetn_in,
  input  wire logic                       req_valid_in,
  input  wire sgigen_pkg::sgigen_req_type req_in,
  output logic [15:0]                     count_out,
  output logic [15:0]                     blocked_out,
  output sgigen_pkg::sgigen_req_type      last_out
);
  // every pulse is taken at once; there is no back-pressure on this path
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_out <= 16'h0000;
      last_out  <= '0;
    end
    else if (req_valid_in)
    begin
      count_out <= count_out + 16'h0001;
      last_out  <= req_in; // mask bits of absent cores just go unused
    end
  end

  // every nonsecure group 0 request is taken, then counted as dropped; no per-target access check is modelled
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
      blocked_out <= 16'h0000;
    else if (req_valid_in & !req_in.secure & !req_in.group1)
      blocked_out <= blocked_out + 16'h0001;
  end
endmodule : sgigen_dist_model
`default_nettype wire

// *** tb/sgigen_regs_bench.sv ***
// sgigen_regs_bench: directed scenarios for the sgi generate registers.
// assumes the design files and the distributor model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sgigen_regs_bench;
  import sgigen_pkg::*;
  localparam logic [63:0] VAL = 64'hFF12_3E56_F978_A5C3; // reserved bits all set
  localparam logic [63:0] ROUTING_MODE_BIT = 64'h0000_0100_0000_0000;
  logic             clock_in, resetn_in, write_valid_in;
  sgigen_write_type write_in;
  sgigen_ctrl_type  ctrl_in, base, c;
  logic             req_valid_out, undef_out, trap_el2_out, trap_el3_out;
  logic [5:0]       trap_code_out;
  sgigen_req_type   req_out, last_req;
  logic [15:0]      dist_count, n, blocked;
  logic [3:0]       got;
  int               errors, checks_done;

  sgigen_regs sgigen_regs_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .write_valid_in(write_valid_in), .write_in(write_in), .ctrl_in(ctrl_in),
    .req_valid_out(req_valid_out), .req_out(req_out), .undef_out(undef_out),
    .trap_el2_out(trap_el2_out), .trap_el3_out(trap_el3_out), .trap_code_out(trap_code_out));
  sgigen_dist_model sgigen_dist_model_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .req_valid_in(req_valid_out), .req_in(req_out), .count_out(dist_count),
    .blocked_out(blocked), .last_out(last_req));

  task automatic check(input logic [63:0] g, input logic [63:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : check

  // one write; outcome sampled once the answering edge has landed
  task automatic wr(input logic [3:0] opc, input logic [3:0] crm, input logic [63:0] v,
                    input sgigen_el_type el, input logic mon, input sgigen_ctrl_type k);
    @(posedge clock_in);
    write_valid_in <= 1'b1;
    write_in <= '{SGIGEN_COPROC, crm, opc, v[31:0], v[63:32], el, mon};
    ctrl_in <= k;
    @(posedge clock_in);
    write_valid_in <= 1'b0;
    #1;
    got = {req_valid_out, undef_out, trap_el2_out, trap_el3_out};
  endtask : wr

  // e is {request, undefined, trap to el2, trap to el3}
  task automatic go(input logic [3:0] opc, input logic [63:0] v, input sgigen_el_type el,
                    input logic mon, input logic [3:0] e);
    n = dist_count;
    wr(opc, SGIGEN_CRM, v, el, mon, c);
    check(got, e, "outcome");
    check(trap_code_out, e[1] ? 6'h03 : 6'h00, "trap code");
    @(posedge clock_in);
    #1;
    check(dist_count, n + e[3], "request count");
  endtask : go

  task automatic t_fields;
    c = base;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    check(last_req, {24'h125678, 4'h3, 4'h9, 16'hA5C3, 3'b011}, "fields");
    go(SGIGEN_OPC_GRP1, VAL | ROUTING_MODE_BIT, SGIGEN_EL1, 1'b0, 4'h8);
    check({last_req[50:27], last_req[18:2]}, 64'h1, "broadcast");
    go(SGIGEN_OPC_GRP0, VAL, SGIGEN_EL3, 1'b0, 4'h8);
    check(last_req.group1, 1'b0, "group 0");
    c.nonsecure_bit = 1'b1;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    check(last_req.secure, 1'b0, "nonsecure");
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b1, 4'h8);
    check(last_req.secure, 1'b1, "monitor");
    go(SGIGEN_OPC_GRP0, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    check({last_req.group1, last_req.secure}, 2'b00, "nonsecure group 0");
    check(blocked, 16'h0001, "nonsecure group 0 held back");
    $display("test fields done");
  endtask : t_fields

  task automatic t_access;
    c = base;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL0, 1'b0, 4'h4);
    c.system_register_enable = 1'b0;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h4);
    c.el2_enabled = 1'b1;
    c.trap_coprocessor_c12 = 1'b1;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h2);
    c = base;
    c.hyp_system_register_enable = 1'b0;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL2, 1'b0, 4'h4);
    c = base;
    c.monitor_system_register_enable = 1'b0;
    go(SGIGEN_OPC_GRP0, VAL, SGIGEN_EL3, 1'b0, 4'h4);
    // each of the other three hypervisor controls alone must trap
    for (int k = 0; k < 3; k++)
    begin
      c = base;
      c.el2_enabled = 1'b1;
      {c.trap_common_regs, c.fiq_route_to_hyp, c.irq_route_to_hyp} = 3'h4 >> k;
      go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h2);
    end
    c.el2_enabled = 1'b0;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    c = base;
    c.el3_present = 1'b1;
    c.irq_fiq_route = SGIGEN_ROUTE_MON;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL2, 1'b0, 4'h1);
    go(SGIGEN_OPC_GRP0, VAL, SGIGEN_EL1, 1'b0, 4'h1);
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b1, 4'h8);
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL3, 1'b0, 4'h8);
    c.irq_fiq_route = 2'h1;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL2, 1'b0, 4'h8);
    $display("test access done");
  endtask : t_access

  task automatic t_encode;
    wr(SGIGEN_OPC_GRP1, 4'hD, VAL, SGIGEN_EL1, 1'b0, base);
    check(got, 4'h0, "wrong crm");
    wr(4'h1, SGIGEN_CRM, VAL, SGIGEN_EL1, 1'b0, base);
    check(got, 4'h0, "wrong opcode");
    $display("test encode done");
  endtask : t_encode

  task automatic t_range;
    c = base;
    c.range_select_support = 1'b0;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    check(last_req.range_selector, 4'h0, "selector off");
    c = base;
    c.dist_range_support = 1'b0;
    c.rs_nonzero_ignores = 1'b1;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h0);
    c.rs_nonzero_ignores = 1'b0;
    go(SGIGEN_OPC_GRP1, VAL, SGIGEN_EL1, 1'b0, 4'h8);
    check(last_req.range_selector, 4'h0, "selector zeroed");
    $display("test range done");
  endtask : t_range

  // two writes on consecutive edges must give two requests
  task automatic t_b2b;
    n = dist_count;
    @(posedge clock_in);
    write_valid_in <= 1'b1;
    write_in <= '{SGIGEN_COPROC, SGIGEN_CRM, SGIGEN_OPC_GRP1, VAL[31:0], VAL[63:32],
                  SGIGEN_EL1, 1'b0};
    ctrl_in <= base;
    @(posedge clock_in);
    write_in.opc1 <= SGIGEN_OPC_GRP0;
    #1;
    check(req_valid_out, 1'b1, "first pulse");
    check(req_out.group1, 1'b1, "first group");
    @(posedge clock_in);
    write_valid_in <= 1'b0;
    #1;
    check(req_valid_out, 1'b1, "second pulse");
    check(req_out.group1, 1'b0, "second group");
    @(posedge clock_in);
    #1;
    check(dist_count, n + 16'h0002, "two requests");
    $display("test back to back done");
  endtask : t_b2b

  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end

  // cut a hang short; the tests need fewer than a hundred cycles
  initial
  begin
    #50000;
    errors++;
    test_done;
  end

  initial
  begin
    base = 15'h0386; // all three register enables and range support on, el2 off, no traps
    clock_in = 1'b0;
    resetn_in = 1'b0;
    write_valid_in = 1'b0;
    write_in = '0;
    ctrl_in = base;
    errors = 0;
    checks_done = 0;
    repeat (5) @(posedge clock_in);
    check({req_valid_out, undef_out, trap_el2_out, trap_el3_out}, 4'h0, "reset");
    resetn_in <= 1'b1;
    t_fields;
    t_access;
    t_encode;
    t_range;
    t_b2b;
    test_done;
  end
endmodule : sgigen_regs_bench
`default_nettype wire
